// ===== hdl/pusr_pkg.sv
// Package: constants shared by the power-up report link and its FIFO
package pusr_pkg;
   // Clock and serial rate
   localparam int CLK_HZ = 100_000_000;
   localparam int BAUD_BPS = 1200;
   localparam int BIT_CYCLES = CLK_HZ / BAUD_BPS;
   // Time after power-up by which the line must be high
   localparam int MEAS_LOW_MS = 100;
   localparam int MEAS_LOW_CYCLES = MEAS_LOW_MS * (CLK_HZ / 1000);
   // Counter widths able to hold the cycle counts above
   localparam int BIT_CNT_W = 17;
   localparam int LOW_CNT_W = 24;
   // Character framing
   localparam int DATA_BITS = 8;
   localparam logic [3:0] FRAME_BITS_LEFT = 4'h9;
   // Character codes
   localparam logic [7:0] CHAR_TAB = 8'h09;
   localparam logic [7:0] CHAR_CR = 8'h0d;
   localparam logic [7:0] CHAR_LF = 8'h0a;
   localparam logic [7:0] CHAR_QUERY = 8'h3f;
   localparam logic [7:0] CHAR_BANG = 8'h21;
   localparam logic [7:0] ADDR_ZERO = 8'h30;
   localparam logic [7:0] SUM_OFFSET = 8'h20;
   // Sensor type character; the value is arbitrary
   localparam logic [7:0] TYPE_CHAR_DEFAULT = 8'h54;
   // Metadata FIFO shape
   localparam int META_WIDTH = 8;
   localparam int META_DEPTH = 8;
   // Sequencer states
   typedef enum logic [3:0] {
      ST_INIT,
      ST_LOW,
      ST_HIGH,
      ST_TAB,
      ST_META,
      ST_CR1,
      ST_TYPE,
      ST_SUM,
      ST_CR2,
      ST_LF,
      ST_END,
      ST_CMD
   } pusr_state_t;
endpackage : pusr_pkg

// ===== hdl/pusr_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
module pusr_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Filling side
   input wire logic inValid,
   input wire logic [WIDTH-1:0] inData,
   output logic inReady,
   // Draining side
   output logic outValid,
   output logic [WIDTH-1:0] outData,
   input wire logic outReady
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr_reg;
   logic [AW-1:0] rdPtr_reg;
   logic [AW:0] count_reg;
   logic [AW:0] count_next;
   logic push;
   logic pop;

   ////////////////////////////////////////////////////////////////////////
   // Handshakes; inReady is registered so the source sees a clean flop
   assign push = inValid && inReady;
   assign pop = outValid && outReady;
   assign outValid = (count_reg != '0);
   assign outData = mem[rdPtr_reg];

   // Occupancy
   always_comb begin
      count_next = count_reg;
      if (push && !pop) begin
         count_next = count_reg + 1'b1;
      end else if (pop && !push) begin
         count_next = count_reg - 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         count_reg <= '0;
         inReady <= 1'b0;
      end else begin
         count_reg <= count_next;
         inReady <= (count_next != (AW+1)'(DEPTH));
      end
   end

   // Pointers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
      end else begin
         if (push) begin
            wrPtr_reg <= (wrPtr_reg == AW'(DEPTH-1)) ? '0 : wrPtr_reg + 1'b1;
         end
         if (pop) begin
            rdPtr_reg <= (rdPtr_reg == AW'(DEPTH-1)) ? '0 : rdPtr_reg + 1'b1;
         end
      end
   end

   // Storage, no reset needed
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr_reg] <= inData;
      end
   end
endmodule : pusr_fifo

// ===== hdl/pusr_link.sv
// Power-up serial report sender and address-query responder on one wire
`timescale 1ns/1ns
module pusr_link
   import pusr_pkg::*;
#(
   parameter int BIT_CYC = pusr_pkg::BIT_CYCLES,
   parameter int LOW_CYC = pusr_pkg::MEAS_LOW_CYCLES,
   parameter logic [7:0] TYPE_CHAR = pusr_pkg::TYPE_CHAR_DEFAULT
) (
   // Clock and power-cycle reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Data line, split into its three signals
   input wire logic lineIn,
   output logic lineOut,
   output logic lineOe,
   // Configured bus address
   input wire logic [7:0] cfgAddr,
   input wire logic cfgAddrValid,
   // Measurement status from the sensor core
   input wire logic measLowDone,
   input wire logic measDone,
   // Metadata characters, one per beat
   input wire logic metaValid,
   input wire logic [pusr_pkg::META_WIDTH-1:0] metaData,
   input wire logic metaLast,
   output logic metaReady,
   // Mode status
   output logic cmdMode
);
   import pusr_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   pusr_state_t state_reg;
   logic [7:0] addr_reg;
   logic [LOW_CNT_W-1:0] lowCnt_reg;
   logic [5:0] sum_reg;
   logic fifoValid;
   logic [META_WIDTH:0] fifoData;
   logic fifoPop;
   logic fifoReady;
   // Transmitter
   logic txBusy_reg;
   logic [DATA_BITS:0] txShift_reg;
   logic [3:0] txLeft_reg;
   logic [BIT_CNT_W-1:0] txCnt_reg;
   logic txLoad;
   logic [7:0] txChar;
   logic txTick;
   // Receiver
   logic rxMeta_reg;
   logic rxSync_reg;
   logic rxBusy_reg;
   logic [3:0] rxLeft_reg;
   logic [BIT_CNT_W-1:0] rxCnt_reg;
   logic [7:0] rxShift_reg;
   logic rxDone;
   logic querySeen_reg;
   logic qMark_reg;
   logic replyGo;

   ////////////////////////////////////////////////////////////////////////
   // Metadata FIFO; last flag rides as the top bit
   pusr_fifo #(
      .WIDTH(META_WIDTH + 1),
      .DEPTH(META_DEPTH)
   ) metaFifo (
      .clk(ref_clk),
      .rstn(rstn),
      .inValid(metaValid),
      .inData({metaLast, metaData}),
      .inReady(fifoReady),
      .outValid(fifoValid),
      .outData(fifoData),
      .outReady(fifoPop)
   );

   // Ready comes from the FIFO's own flop
   assign metaReady = fifoReady;

   ////////////////////////////////////////////////////////////////////////
   // Address capture one edge after reset release
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         addr_reg <= ADDR_ZERO;
      end else if (state_reg == ST_INIT) begin
         // Unprogrammed store means shipped address zero
         addr_reg <= cfgAddrValid ? cfgAddr : ADDR_ZERO;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Character selection for the report sequencer
   always_comb begin
      txLoad = 1'b0;
      txChar = CHAR_TAB;
      fifoPop = 1'b0;
      replyGo = 1'b0;
      if (!txBusy_reg) begin
         case (state_reg)
            ST_TAB: begin
               txLoad = 1'b1;
               txChar = CHAR_TAB;
            end
            ST_META: begin
               txLoad = fifoValid;
               txChar = fifoData[META_WIDTH-1:0];
               fifoPop = fifoValid;
            end
            ST_CR1: begin
               txLoad = 1'b1;
               txChar = CHAR_CR;
            end
            ST_TYPE: begin
               txLoad = 1'b1;
               txChar = TYPE_CHAR;
            end
            ST_SUM: begin
               txLoad = 1'b1;
               txChar = {2'b00, sum_reg} + SUM_OFFSET;
            end
            ST_CR2: begin
               txLoad = 1'b1;
               txChar = CHAR_CR;
            end
            ST_LF: begin
               txLoad = 1'b1;
               txChar = CHAR_LF;
            end
            ST_CMD: begin
               // Reply is only the address character
               replyGo = querySeen_reg && !rxBusy_reg;
               txLoad = replyGo;
               txChar = addr_reg;
            end
            default: begin
               txLoad = 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Power-up sequencer
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= ST_INIT;
      end else begin
         case (state_reg)
            ST_INIT: begin
               // Non-zero address skips straight to command mode
               if ((cfgAddrValid ? cfgAddr : ADDR_ZERO) != ADDR_ZERO) begin
                  state_reg <= ST_CMD;
               end else begin
                  state_reg <= ST_LOW;
               end
            end
            ST_LOW: begin
               // Core's word or deadline, three short for the init cycle and the two flops after
               if (measLowDone || lowCnt_reg == LOW_CNT_W'(LOW_CYC - 3)) begin
                  state_reg <= ST_HIGH;
               end
            end
            ST_HIGH: begin
               // Extra measuring may last as long as it needs
               if (measDone) begin
                  state_reg <= ST_TAB;
               end
            end
            ST_TAB: begin
               if (txLoad) begin
                  state_reg <= ST_META;
               end
            end
            ST_META: begin
               if (txLoad && fifoData[META_WIDTH]) begin
                  state_reg <= ST_CR1;
               end
            end
            ST_CR1: begin
               if (txLoad) begin
                  state_reg <= ST_TYPE;
               end
            end
            ST_TYPE: begin
               if (txLoad) begin
                  state_reg <= ST_SUM;
               end
            end
            ST_SUM: begin
               if (txLoad) begin
                  state_reg <= ST_CR2;
               end
            end
            ST_CR2: begin
               if (txLoad) begin
                  state_reg <= ST_LF;
               end
            end
            ST_LF: begin
               if (txLoad) begin
                  state_reg <= ST_END;
               end
            end
            ST_END: begin
               // Wait out the line feed's stop bit
               if (!txBusy_reg) begin
                  state_reg <= ST_CMD;
               end
            end
            ST_CMD: begin
               // Only a reset leaves command mode
               state_reg <= ST_CMD;
            end
            default: begin
               state_reg <= ST_INIT;
            end
         endcase
      end
   end

   // Low-phase timer
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         lowCnt_reg <= '0;
      end else if (state_reg == ST_LOW) begin
         lowCnt_reg <= lowCnt_reg + 1'b1;
      end
   end

   // Running checksum, tab through first return, kept modulo 64
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         sum_reg <= '0;
      end else if (txLoad && (state_reg == ST_TAB ||
                              state_reg == ST_META ||
                              state_reg == ST_CR1)) begin
         sum_reg <= sum_reg + txChar[5:0];
      end
   end

   // Mode flag
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         cmdMode <= 1'b0;
      end else begin
         cmdMode <= (state_reg == ST_CMD);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transmit bit timer
   assign txTick = (txCnt_reg == BIT_CNT_W'(BIT_CYC - 1));

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         txCnt_reg <= '0;
      end else if (txLoad || txTick) begin
         txCnt_reg <= '0;
      end else if (txBusy_reg) begin
         txCnt_reg <= txCnt_reg + 1'b1;
      end
   end

   // Shifter: start bit at load, then data LSB first, then stop
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         txBusy_reg <= 1'b0;
         txShift_reg <= '1;
         txLeft_reg <= '0;
      end else if (txLoad) begin
         txBusy_reg <= 1'b1;
         txShift_reg <= {1'b1, txChar};
         txLeft_reg <= FRAME_BITS_LEFT;
      end else if (txBusy_reg && txTick) begin
         if (txLeft_reg != '0) begin
            txShift_reg <= {1'b1, txShift_reg[DATA_BITS:1]};
            txLeft_reg <= txLeft_reg - 1'b1;
         end else begin
            // Stop bit has lasted a full bit time
            txBusy_reg <= 1'b0;
         end
      end
   end

   // Line level; low only for measuring, start and zero bits
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         lineOut <= 1'b0;
      end else if (txLoad) begin
         lineOut <= 1'b0;
      end else if (txBusy_reg && txTick) begin
         lineOut <= (txLeft_reg != '0) ? txShift_reg[0] : 1'b1;
      end else if (state_reg == ST_LOW || state_reg == ST_INIT) begin
         lineOut <= 1'b0;
      end else if (!txBusy_reg) begin
         lineOut <= 1'b1;
      end
   end

   // Drive enable; released to listen in command mode
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         lineOe <= 1'b1;
      end else if (state_reg == ST_CMD) begin
         lineOe <= txLoad || txBusy_reg;
      end else begin
         lineOe <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Line input synchroniser
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rxMeta_reg <= 1'b1;
         rxSync_reg <= 1'b1;
      end else begin
         rxMeta_reg <= lineIn;
         rxSync_reg <= rxMeta_reg;
      end
   end

   // Receiver: half-bit to mid start, then whole bits
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rxBusy_reg <= 1'b0;
         rxLeft_reg <= '0;
         rxCnt_reg <= '0;
         rxShift_reg <= '0;
      end else if (!rxBusy_reg) begin
         // Listening only while in command mode and not replying
         if (state_reg == ST_CMD && !lineOe && !rxSync_reg) begin
            rxBusy_reg <= 1'b1;
            rxLeft_reg <= FRAME_BITS_LEFT;
            rxCnt_reg <= BIT_CNT_W'(BIT_CYC / 2);
         end
      end else if (rxCnt_reg == BIT_CNT_W'(BIT_CYC - 1)) begin
         rxCnt_reg <= '0;
         if (rxLeft_reg == FRAME_BITS_LEFT && rxSync_reg) begin
            // Glitch, not a real start bit
            rxBusy_reg <= 1'b0;
         end else if (rxLeft_reg == 4'h0) begin
            rxBusy_reg <= 1'b0;
         end else begin
            if (rxLeft_reg != FRAME_BITS_LEFT) begin
               rxShift_reg <= {rxSync_reg, rxShift_reg[7:1]};
            end
            rxLeft_reg <= rxLeft_reg - 1'b1;
         end
      end else begin
         rxCnt_reg <= rxCnt_reg + 1'b1;
      end
   end

   // Character complete at mid stop bit, stop level high
   assign rxDone = rxBusy_reg && rxLeft_reg == 4'h0 && rxSync_reg &&
                   rxCnt_reg == BIT_CNT_W'(BIT_CYC - 1);

   // Query detector; the query names no address at all
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         querySeen_reg <= 1'b0;
      end else if (replyGo) begin
         querySeen_reg <= 1'b0;
      end else if (rxDone) begin
         querySeen_reg <= 1'b0;
         if (rxShift_reg == CHAR_BANG && qMark_reg) begin
            querySeen_reg <= 1'b1;
         end
      end
   end

   // Remembers that the previous character was the query mark
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         qMark_reg <= 1'b0;
      end else if (rxDone) begin
         qMark_reg <= (rxShift_reg == CHAR_QUERY);
      end
   end
endmodule : pusr_link

// ===== testbench/pusr_link_sva.sv
// Checker: line timing and mode properties of the report link
`timescale 1ns/1ns
module pusr_link_sva
   import pusr_pkg::*;
#(
   parameter int BIT_CYC = 16,
   parameter int LOW_CYC = 64
) (
   // Clock and reset
   input logic ref_clk,
   input logic rstn,
   // Line and mode
   input logic lineOut,
   input logic lineOe,
   input logic cmdMode,
   // Configuration and measurement
   input logic [7:0] cfgAddr,
   input logic cfgAddrValid,
   input logic measLowDone
);
   ////////////////////////////////////////////////////////////////////
   logic [7:0] cycReg;
   logic firstHighReg;
   logic [15:0] lowRunReg;
   // Cycles since release, saturating so it never wraps
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) cycReg <= 8'h00;
      else if (cycReg != 8'hff) cycReg <= cycReg + 8'h01;
   end
   // Set once the line has been raised for the report
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) firstHighReg <= 1'b0;
      else if (lineOe && lineOut && !cmdMode) firstHighReg <= 1'b1;
   end
   // Length of the current low run; bit cells must tile it exactly
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) lowRunReg <= 16'h0000;
      else if (lineOe && !lineOut) lowRunReg <= lowRunReg + 16'h0001;
      else lowRunReg <= 16'h0000;
   end
   ////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   property p_low_hold;
      cycReg < LOW_CYC - 4 && !cmdMode && !measLowDone &&
      !$past(measLowDone) && !$past(measLowDone, 2) |-> !lineOut;
   endproperty
   a_low_hold: assert property (p_low_hold)
      else $error("line raised during initial measurement");
   property p_raise;
      cycReg == LOW_CYC && !cmdMode |-> firstHighReg || (lineOe && lineOut);
   endproperty
   a_raise: assert property (p_raise)
      else $error("line not raised by the deadline");
   property p_low_run;
      firstHighReg && !cmdMode && lineOut && !$past(lineOut) |->
      lowRunReg % BIT_CYC == 0 && lowRunReg != 16'h0000;
   endproperty
   a_low_run: assert property (p_low_run)
      else $error("low run not a whole number of bit cells");
   property p_oe_report;
      firstHighReg && !cmdMode |-> lineOe;
   endproperty
   a_oe_report: assert property (p_oe_report)
      else $error("line released during the report");
   property p_cmd_stay;
      cmdMode |=> cmdMode;
   endproperty
   a_cmd_stay: assert property (p_cmd_stay)
      else $error("command mode left without power cycle");
   property p_cmd_release;
      $rose(cmdMode) |-> ##[0:3] !lineOe;
   endproperty
   a_cmd_release: assert property (p_cmd_release)
      else $error("line still driven after entering command mode");
   property p_addr_skip;
      cycReg == 8'h04 && cfgAddrValid && cfgAddr != ADDR_ZERO |->
      cmdMode && !lineOe;
   endproperty
   a_addr_skip: assert property (p_addr_skip)
      else $error("report started with non-zero address");
   property p_addr_default;
      cycReg == 8'h04 && (!cfgAddrValid || cfgAddr == ADDR_ZERO) |->
      !cmdMode && lineOe;
   endproperty
   a_addr_default: assert property (p_addr_default)
      else $error("zero address did not start the report");
endmodule : pusr_link_sva
bind pusr_link pusr_link_sva #(.BIT_CYC(BIT_CYC), .LOW_CYC(LOW_CYC)) chk (
   .ref_clk(ref_clk), .rstn(rstn), .lineOut(lineOut), .lineOe(lineOe),
   .cmdMode(cmdMode), .cfgAddr(cfgAddr), .cfgAddrValid(cfgAddrValid),
   .measLowDone(measLowDone));

// ===== testbench/pusr_logger.sv
// Data logger model: receives 8N1 frames and sends address queries
`timescale 1ns/1ns
module pusr_logger #(
   parameter int BIT_CYC = 16
) (
   // Clock
   input logic clk,
   // Resolved line and receive enable
   input logic line,
   input logic rxEn,
   // Logger drive onto the line
   output logic txOe,
   output logic txOut
);
   ////////////////////////////////////////////////////////////////////
   logic [8:0] rxQ[$];
   logic lastLevel;
   logic [8:0] frame;
   int i;
   initial begin
      txOe = 1'b0;
      txOut = 1'b1;
      lastLevel = 1'b0;
   end
   // Only a fall from high opens a frame, so the low measuring phase
   // and the raise before the report are never taken as data; a low
   // line while the logger still drives its stop high is the reply
   always @(posedge clk) begin
      if (rxEn && (!txOe || txOut) && lastLevel && !line) begin
         repeat (BIT_CYC / 2) @(posedge clk);
         for (i = 0; i < 9; i++) begin
            repeat (BIT_CYC) @(posedge clk);
            frame[i] = line;
         end
         rxQ.push_back(frame);
      end
      lastLevel = line;
   end
   // One 8N1 character, LSB first; caller holds txOe
   task sendChar(input logic [7:0] c);
      int k;
      txOut <= 1'b0;
      repeat (BIT_CYC) @(posedge clk);
      for (k = 0; k < 8; k++) begin
         txOut <= c[k];
         repeat (BIT_CYC) @(posedge clk);
      end
      txOut <= 1'b1;
      repeat (BIT_CYC) @(posedge clk);
   endtask : sendChar
   // Address query; only sent with one sensor on the line
   task sendQuery();
      @(posedge clk);
      txOe <= 1'b1;
      txOut <= 1'b1;
      repeat (BIT_CYC) @(posedge clk);
      sendChar(pusr_pkg::CHAR_QUERY);
      sendChar(pusr_pkg::CHAR_BANG);
      txOe <= 1'b0;
   endtask : sendQuery
endmodule : pusr_logger

// ===== testbench/pusr_link_tb.sv
// Testbench: report, query and power-cycle scenarios against a model
`timescale 1ns/1ns
module pusr_link_tb;
   import pusr_pkg::*;
   localparam int BIT_C = 16;
   localparam int LOW_C = 64;
   localparam int LIMIT = 20000;
   logic ref_clk, rstn, busLine, lineOut, lineOe, logOe, logOut, rxEn;
   logic cfgAddrValid, measLowDone, measDone, metaValid, metaLast;
   logic metaReady, cmdMode;
   logic [7:0] cfgAddr, metaData;
   logic [31:0] rnd;
   logic [7:0] expQ[$], metaQ[$];
   int nMismatch, totalChecks, cycles, k;
   string ex;
   ////////////////////////////////////////////////////////////////////
   pusr_link #(.BIT_CYC(BIT_C), .LOW_CYC(LOW_C)) DUT (
      .ref_clk(ref_clk), .rstn(rstn), .lineIn(busLine), .lineOut(lineOut),
      .lineOe(lineOe), .cfgAddr(cfgAddr), .cfgAddrValid(cfgAddrValid),
      .measLowDone(measLowDone), .measDone(measDone),
      .metaValid(metaValid), .metaData(metaData), .metaLast(metaLast),
      .metaReady(metaReady), .cmdMode(cmdMode));
   pusr_logger #(.BIT_CYC(BIT_C)) LOG (.clk(ref_clk), .line(busLine),
      .rxEn(rxEn), .txOe(logOe), .txOut(logOut));
   // Undriven line floats high through the pull-up
   assign busLine = lineOe ? lineOut : (logOe ? logOut : 1'b1);
   // Clock
   always #5 ref_clk = ~ref_clk;
   // Hang guard
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         nMismatch++;
         testDone();
      end
   end
   ////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task cmpByte(input logic [8:0] got, input logic [8:0] exp);
      totalChecks++;
      if (got !== exp) begin
         nMismatch++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmpByte
   task cmpBit(input logic got, input logic exp);
      totalChecks++;
      if (got !== exp) begin
         nMismatch++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmpBit
   task testDone();
      $display("checks %0d mismatches %0d", totalChecks, nMismatch);
      if (nMismatch == 0 && totalChecks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : testDone
   // Power cycle: the sensor restarts from its initial state with the given address
   task power(input logic valid, input logic [7:0] addr);
      @(posedge ref_clk);
      rxEn <= 1'b0;
      rstn <= 1'b0;
      measLowDone <= 1'b0;
      measDone <= 1'b0;
      cfgAddrValid <= valid;
      cfgAddr <= addr;
      repeat (6) @(posedge ref_clk);
      rstn <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rxEn <= 1'b1;
      LOG.rxQ.delete();
   endtask : power
   // Builds the expected report and pushes metaQ; with fill set the
   // FIFO is filled before measuring ends, so it must refuse
   task feed(input logic fill);
      int j, sum, n;
      n = metaQ.size();
      expQ = {CHAR_TAB};
      for (j = 0; j < n; j++) expQ.push_back(metaQ[j]);
      expQ.push_back(CHAR_CR);
      sum = 0;
      for (j = 0; j < expQ.size(); j++) sum += expQ[j];
      expQ.push_back(TYPE_CHAR_DEFAULT);
      expQ.push_back(8'(sum % 64 + 32));
      expQ.push_back(CHAR_CR);
      expQ.push_back(CHAR_LF);
      for (j = 0; j < n; j++) begin
         metaValid <= 1'b1;
         metaData <= metaQ[j];
         metaLast <= (j == n - 1);
         @(posedge ref_clk);
         while (!metaReady) @(posedge ref_clk);
         rnd = lfsr(rnd);
         if (fill && j == META_DEPTH - 1) begin
            metaValid <= 1'b0;
            repeat (2) @(posedge ref_clk);
            cmpBit(metaReady, 1'b0);
            measDone <= 1'b1;
         end else if (rnd[1:0] != 2'b00 && j != n - 1) begin
            metaValid <= 1'b0;
            repeat (rnd[1:0]) @(posedge ref_clk);
         end
      end
      metaValid <= 1'b0;
      metaQ.delete();
   endtask : feed
   // Waits for command mode, then matches every received frame
   task checkReport();
      int w;
      w = 0;
      while (cmdMode !== 1'b1 && w < 10000) begin
         @(posedge ref_clk);
         w++;
      end
      cmpBit(cmdMode, 1'b1);
      cmpByte(9'(LOG.rxQ.size()), 9'(expQ.size()));
      while (expQ.size() > 0 && LOG.rxQ.size() > 0)
         cmpByte(LOG.rxQ.pop_front(), {1'b1, expQ.pop_front()});
   endtask : checkReport
   // Address query and its one-character reply
   task query(input logic [7:0] addr);
      int w;
      LOG.sendQuery();
      w = 0;
      while (LOG.rxQ.size() == 0 && w < 1000) begin
         @(posedge ref_clk);
         w++;
      end
      cmpByte(9'(LOG.rxQ.size()), 9'h001);
      if (LOG.rxQ.size() > 0)
         cmpByte(LOG.rxQ.pop_front(), {1'b1, addr});
   endtask : query
   ////////////////////////////////////////////////////////////////////
   initial begin
      ref_clk = 1'b0;
      rstn = 1'b0;
      rxEn = 1'b0;
      cfgAddr = ADDR_ZERO;
      cfgAddrValid = 1'b0;
      measLowDone = 1'b0;
      measDone = 1'b0;
      metaValid = 1'b0;
      metaData = 8'h00;
      metaLast = 1'b0;
      nMismatch = 0;
      totalChecks = 0;
      cycles = 0;
      rnd = 32'h356d;
      // Shipped address, early raise, FIFO full before measuring ends
      power(1'b0, ADDR_ZERO);
      rnd = lfsr(rnd);
      repeat (rnd[3:0]) @(posedge ref_clk);
      measLowDone <= 1'b1;
      ex = "9.81 9.98 13.99 24.3";
      for (k = 0; k < ex.len(); k++) metaQ.push_back(ex[k]);
      feed(1'b1);
      checkReport();
      query(ADDR_ZERO);
      // Non-zero address: no report, query still answered
      power(1'b1, 8'h35);
      repeat (200) @(posedge ref_clk);
      cmpBit(cmdMode, 1'b1);
      cmpByte(9'(LOG.rxQ.size()), 9'h000);
      query(8'h35);
      // Programmed zero address, raise on deadline, report again
      power(1'b1, ADDR_ZERO);
      measDone <= 1'b1;
      for (k = 0; k < 6; k++) begin
         rnd = lfsr(rnd);
         metaQ.push_back(rnd[3:0] > 4'h9 ? 8'h20 : {4'h3, rnd[3:0]});
      end
      feed(1'b0);
      checkReport();
      testDone();
   end
endmodule : pusr_link_tb
